// File: src/gpiopm_top.sv
`timescale 1ns/1ps
`default_nettype none
module gpiopm_top (
	input wire logic clock,
	input wire logic rst,
	input wire gpiopm_pkg::gpiopm_bus_t bus,
	output logic [31:0] rdata,
	input wire logic [63:0] pin_in,
	output logic [63:0] pin_out,
	output logic [63:0] pin_oe_n,
	input wire logic [63:0] periph_sel,
	input wire logic [63:0] periph_out,
	input wire logic [63:0] periph_oe_n,
	input wire gpiopm_pkg::gpiopm_pwr_t power_mode,
	output logic [7:0] pint_irq,
	output logic [1:0] gint_irq,
	output logic [7:0] pm_irq,
	output logic cpu_receive_event,
	output logic event_pin,
	output logic wake_pint,
	output logic wake_gint,
	output logic wake_pm
);
	import gpiopm_pkg::*;

	// ----------------------------------------
	// Bus lanes
	// ----------------------------------------
	logic [31:0] bm;
	logic [31:0] wd;
	logic [31:0] rv;
	logic [63:0] dir_all;
	logic [63:0] mask_all;
	logic [63:0] out_all;
	logic [63:0] gen_all [2];
	logic [63:0] gpol_all [2];

	always_comb begin
		bm = {{8{bus.be[3]}}, {8{bus.be[2]}}, {8{bus.be[1]}}, {8{bus.be[0]}}};
		wd = bus.wdata;
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [31:0] m);
		merge = (old & ~m) | (d & m);
	endfunction

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	logic [63:0] s1_r;
	logic [63:0] s2_r;
	logic [63:0] s3_r;

	always_ff @(posedge clock) begin
		if (rst) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// ----------------------------------------
	// GPIO ports
	// ----------------------------------------
	for (genvar p = 0; p < 2; p++) begin : g_port
		localparam logic [7:0] PO = 8'(p * 4);
		logic [31:0] dir_r;
		logic [31:0] mask_r;
		logic [31:0] out_r;

		always_ff @(posedge clock) begin
			if (rst) begin
				dir_r <= RST_ZERO;
				mask_r <= RST_ZERO;
			end else if (bus.wr) begin
				if (bus.addr == OFS_DIR + PO)
					dir_r <= merge(dir_r, wd, bm);
				if (bus.addr == OFS_MASK + PO)
					mask_r <= merge(mask_r, wd, bm);
			end
		end

		always_ff @(posedge clock) begin
			if (rst) begin
				out_r <= RST_ZERO;
			end else if (bus.wr) begin
				case (bus.addr)
					OFS_PIN + PO: out_r <= merge(out_r, wd, bm);
					OFS_MPIN + PO: out_r <= merge(out_r, wd, bm & mask_r);
					OFS_SET + PO: out_r <= out_r | (wd & bm);
					OFS_CLR + PO: out_r <= out_r & ~(wd & bm);
					OFS_NOT + PO: out_r <= out_r ^ (wd & bm);
					default: out_r <= out_r;
				endcase
			end
		end

		assign dir_all[32*p +: 32] = dir_r;
		assign mask_all[32*p +: 32] = mask_r;
		assign out_all[32*p +: 32] = out_r;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pin_out <= '0;
			pin_oe_n <= RST_OE_N;
		end else begin
			pin_out <= (periph_sel & periph_out) | (~periph_sel & out_all);
			pin_oe_n <= (periph_sel & periph_oe_n) | (~periph_sel & ~dir_all);
		end
	end

	// ----------------------------------------
	// Pin interrupts
	// ----------------------------------------
	logic [63:0] psel_r;
	logic [7:0] isel_r;
	logic [7:0] ienr_r;
	logic [7:0] ienf_r;
	logic [7:0] ist_r;
	logic [7:0] src;
	logic [7:0] prv;
	logic ist_wr;

	assign ist_wr = bus.wr && bus.addr == OFS_IST;

	always_ff @(posedge clock) begin
		if (rst) begin
			psel_r <= '0;
			isel_r <= '0;
			ienr_r <= '0;
			ienf_r <= '0;
		end else if (bus.wr) begin
			case (bus.addr)
				OFS_PSEL0: psel_r[31:0] <= merge(psel_r[31:0], wd, bm);
				OFS_PSEL1: psel_r[63:32] <= merge(psel_r[63:32], wd, bm);
				OFS_ISEL: isel_r <= 8'(merge(32'(isel_r), wd, bm));
				OFS_IENR: ienr_r <= 8'(merge(32'(ienr_r), wd, bm));
				OFS_IENF: ienf_r <= 8'(merge(32'(ienf_r), wd, bm));
				default: psel_r <= psel_r;
			endcase
		end
	end

	for (genvar i = 0; i < 8; i++) begin : g_pint
		// Selection taps the pin level, not the port function
		assign src[i] = s2_r[psel_r[8*i +: 6]];
		assign prv[i] = s3_r[psel_r[8*i +: 6]];

		always_ff @(posedge clock) begin
			if (rst) begin
				ist_r[i] <= 1'b0;
			end else if (isel_r[i]) begin
				ist_r[i] <= ienr_r[i] & (src[i] == ienf_r[i]);
			end else begin
				// New edge wins over a clear in the same cycle
				ist_r[i] <= (ienr_r[i] & src[i] & ~prv[i])
					| (ienf_r[i] & ~src[i] & prv[i])
					| (ist_r[i] & ~(ist_wr & bus.be[0] & wd[i]));
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pint_irq <= '0;
			wake_pint <= 1'b0;
		end else begin
			pint_irq <= ist_r;
			wake_pint <= |pint_irq && (power_mode == PWR_SLEEP || power_mode == PWR_DEEP);
		end
	end

	// ----------------------------------------
	// Pattern match engine
	// ----------------------------------------
	logic [2:0] pmctrl_r;
	logic [23:0] pmsrc_r;
	logic [7:0] pmend_r;
	logic [23:0] pmcond_r;
	logic [7:0] sticky_r;
	logic [7:0] slice_hit;
	logic [7:0] term;
	logic any_r;
	logic ev_nxt;

	always_ff @(posedge clock) begin
		if (rst) begin
			pmctrl_r <= '0;
			pmsrc_r <= '0;
			pmend_r <= '0;
			pmcond_r <= '0;
		end else if (bus.wr) begin
			case (bus.addr)
				OFS_PMCTRL: pmctrl_r <= 3'(merge(32'(pmctrl_r), wd, bm));
				OFS_PMSRC: pmsrc_r <= 24'(merge(32'(pmsrc_r), wd, bm));
				OFS_PMEND: pmend_r <= 8'(merge(32'(pmend_r), wd, bm));
				OFS_PMCOND: pmcond_r <= 24'(merge(32'(pmcond_r), wd, bm));
				default: pmctrl_r <= pmctrl_r;
			endcase
		end
	end

	for (genvar i = 0; i < 8; i++) begin : g_slice
		logic in_l;
		logic pv_l;
		logic rise;
		logic fall;
		logic [2:0] cnd;

		assign in_l = src[pmsrc_r[3*i +: 3]];
		assign pv_l = prv[pmsrc_r[3*i +: 3]];
		assign rise = in_l & ~pv_l;
		assign fall = ~in_l & pv_l;
		assign cnd = pmcond_r[3*i +: 3];

		// Sticky edges are re-armed by writing the condition register
		always_ff @(posedge clock) begin
			if (rst || (bus.wr && bus.addr == OFS_PMCOND)) begin
				sticky_r[i] <= 1'b0;
			end else if ((cnd == CND_ST_RISE && rise) || (cnd == CND_ST_FALL && fall)
				|| (cnd == CND_ST_EDGE && (rise || fall))) begin
				sticky_r[i] <= 1'b1;
			end
		end

		always_comb begin
			case (cnd)
				CND_ALWAYS: slice_hit[i] = 1'b1;
				CND_ST_RISE: slice_hit[i] = sticky_r[i] | rise;
				CND_ST_FALL: slice_hit[i] = sticky_r[i] | fall;
				CND_ST_EDGE: slice_hit[i] = sticky_r[i] | rise | fall;
				CND_HIGH: slice_hit[i] = in_l;
				CND_LOW: slice_hit[i] = ~in_l;
				CND_NEVER: slice_hit[i] = 1'b0;
				CND_EVENT: slice_hit[i] = rise | fall;
				default: slice_hit[i] = 1'b0;
			endcase
		end
	end

	// Product terms run from one end slice to the next; slice 7 always ends one
	always_comb begin
		logic acc;
		acc = 1'b1;
		for (int i = 0; i < 8; i++) begin
			acc = acc & slice_hit[i];
			term[i] = (pmend_r[i] || i == 7) && acc;
			if (pmend_r[i] || i == 7) begin
				acc = 1'b1;
			end
		end
	end

	assign ev_nxt = pmctrl_r[PMC_EVENT] && pmctrl_r[PMC_ENABLE] && |term && !any_r;

	always_ff @(posedge clock) begin
		if (rst) begin
			pm_irq <= '0;
			any_r <= 1'b0;
			cpu_receive_event <= 1'b0;
			event_pin <= 1'b0;
			wake_pm <= 1'b0;
		end else begin
			pm_irq <= term & {8{pmctrl_r[PMC_ENABLE]}};
			any_r <= |term;
			cpu_receive_event <= ev_nxt;
			event_pin <= ev_nxt && pmctrl_r[PMC_EVPIN];
			wake_pm <= |pm_irq && (power_mode == PWR_ACTIVE || power_mode == PWR_SLEEP);
		end
	end

	// ----------------------------------------
	// Group interrupts
	// ----------------------------------------
	logic [1:0] gand_r;

	always_ff @(posedge clock) begin
		if (rst) begin
			gand_r <= '0;
		end else if (bus.wr && bus.addr == OFS_GCTRL) begin
			gand_r <= 2'(merge(32'(gand_r), wd, bm));
		end
	end

	for (genvar g = 0; g < 2; g++) begin : g_grp
		localparam logic [7:0] GO = 8'(g * 16);
		logic [63:0] en_r;
		logic [63:0] pol_r;
		logic [63:0] hit;

		always_ff @(posedge clock) begin
			if (rst) begin
				en_r <= '0;
				pol_r <= '0;
			end else if (bus.wr) begin
				for (int p = 0; p < 2; p++) begin
					if (bus.addr == OFS_GEN + GO + 8'(p * 4))
						en_r[32*p +: 32] <= merge(en_r[32*p +: 32], wd, bm);
					if (bus.addr == OFS_GPOL + GO + 8'(p * 4))
						pol_r[32*p +: 32] <= merge(pol_r[32*p +: 32], wd, bm);
				end
			end
		end

		assign hit = en_r & ~(s2_r ^ pol_r);
		assign gen_all[g] = en_r;
		assign gpol_all[g] = pol_r;

		always_ff @(posedge clock) begin
			if (rst) begin
				gint_irq[g] <= 1'b0;
			end else if (gand_r[g]) begin
				gint_irq[g] <= |en_r && &(hit | ~en_r);
			end else begin
				gint_irq[g] <= |hit;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wake_gint <= 1'b0;
		end else begin
			wake_gint <= |gint_irq && power_mode != PWR_ACTIVE;
		end
	end

	// ----------------------------------------
	// Register read, one cycle after the strobe
	// ----------------------------------------
	always_comb begin
		rv = '0;
		case (bus.addr)
			OFS_DIR: rv = dir_all[31:0];
			OFS_DIR + PORT_STEP: rv = dir_all[63:32];
			OFS_MASK: rv = mask_all[31:0];
			OFS_MASK + PORT_STEP: rv = mask_all[63:32];
			OFS_PIN: rv = s2_r[31:0];
			OFS_PIN + PORT_STEP: rv = s2_r[63:32];
			OFS_MPIN: rv = s2_r[31:0] & mask_all[31:0];
			OFS_MPIN + PORT_STEP: rv = s2_r[63:32] & mask_all[63:32];
			OFS_SET, OFS_CLR, OFS_NOT: rv = out_all[31:0];
			OFS_SET + PORT_STEP, OFS_CLR + PORT_STEP, OFS_NOT + PORT_STEP: rv = out_all[63:32];
			OFS_PSEL0: rv = psel_r[31:0];
			OFS_PSEL1: rv = psel_r[63:32];
			OFS_ISEL: rv = {24'h000000, isel_r};
			OFS_IENR: rv = {24'h000000, ienr_r};
			OFS_IENF: rv = {24'h000000, ienf_r};
			OFS_IST: rv = {24'h000000, ist_r};
			OFS_PMCTRL: rv = {29'h00000000, pmctrl_r};
			OFS_PMSRC: rv = {8'h00, pmsrc_r};
			OFS_PMEND: rv = {24'h000000, pmend_r};
			OFS_PMCOND: rv = {8'h00, pmcond_r};
			OFS_GEN: rv = gen_all[0][31:0];
			OFS_GEN + PORT_STEP: rv = gen_all[0][63:32];
			OFS_GPOL: rv = gpol_all[0][31:0];
			OFS_GPOL + PORT_STEP: rv = gpol_all[0][63:32];
			OFS_GEN + GRP_STEP: rv = gen_all[1][31:0];
			OFS_GEN + GRP_STEP + PORT_STEP: rv = gen_all[1][63:32];
			OFS_GPOL + GRP_STEP: rv = gpol_all[1][31:0];
			OFS_GPOL + GRP_STEP + PORT_STEP: rv = gpol_all[1][63:32];
			OFS_GCTRL: rv = {30'h00000000, gand_r};
			OFS_GSTAT: rv = {30'h00000000, gint_irq};
			default: rv = '0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata <= '0;
		end else begin
			rdata <= bus.rd ? rv : '0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_reset_input;
		@(posedge clock) $fell(rst) |-> pin_oe_n == RST_OE_N;
	endproperty
	a_reset_input: assert property (p_reset_input) else $error("pins not inputs after reset");

	property p_set_bits;
		@(posedge clock) disable iff (rst)
		bus.wr && bus.addr == OFS_SET && bus.be == 4'hF
		|=> g_port[0].out_r == ($past(g_port[0].out_r) | $past(bus.wdata));
	endproperty
	a_set_bits: assert property (p_set_bits) else $error("set write wrong");

	property p_masked_write;
		@(posedge clock) disable iff (rst)
		bus.wr && bus.addr == OFS_MPIN
		|=> (g_port[0].out_r & ~$past(g_port[0].mask_r))
			== ($past(g_port[0].out_r) & ~$past(g_port[0].mask_r));
	endproperty
	a_masked_write: assert property (p_masked_write) else $error("mask bit changed");

	property p_whole_write;
		@(posedge clock) disable iff (rst)
		bus.wr && bus.addr == OFS_PIN && bus.be == 4'hF |=> g_port[0].out_r == $past(bus.wdata);
	endproperty
	a_whole_write: assert property (p_whole_write) else $error("port write wrong");

	property p_pending_holds;
		@(posedge clock) disable iff (rst)
		ist_r[0] && !isel_r[0] && !(ist_wr && bus.be[0] && wd[0]) |=> ist_r[0] ##1 pint_irq[0];
	endproperty
	a_pending_holds: assert property (p_pending_holds) else $error("pending edge lost");

	property p_pm_wake;
		@(posedge clock) disable iff (rst)
		wake_pm |-> $past(power_mode) == PWR_ACTIVE || $past(power_mode) == PWR_SLEEP;
	endproperty
	a_pm_wake: assert property (p_pm_wake) else $error("pattern wake in deep state");

	property p_pint_wake;
		@(posedge clock) disable iff (rst)
		wake_pint |-> $past(pint_irq) != 8'h00
			&& ($past(power_mode) == PWR_SLEEP || $past(power_mode) == PWR_DEEP);
	endproperty
	a_pint_wake: assert property (p_pint_wake) else $error("pin wake without cause");

	property p_pin_read;
		@(posedge clock) disable iff (rst)
		bus.rd && bus.addr == OFS_PIN |=> rdata == $past(s2_r[31:0]);
	endproperty
	a_pin_read: assert property (p_pin_read) else $error("pin read wrong");

	property p_sync_depth;
		@(posedge clock) disable iff (rst)
		!$past(rst) && !$past(rst, 2) |-> s2_r == $past(pin_in, 2);
	endproperty
	a_sync_depth: assert property (p_sync_depth) else $error("synchroniser depth wrong");

	property p_event_pulse;
		@(posedge clock) disable iff (rst)
		cpu_receive_event |=> !cpu_receive_event;
	endproperty
	a_event_pulse: assert property (p_event_pulse) else $error("event longer than one cycle");

endmodule
`default_nettype wire

// File: src/gpiopm_pkg.sv
`default_nettype none
package gpiopm_pkg;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_DIR = 8'h00;
	localparam logic [7:0] OFS_MASK = 8'h10;
	localparam logic [7:0] OFS_PIN = 8'h20;
	localparam logic [7:0] OFS_MPIN = 8'h30;
	localparam logic [7:0] OFS_SET = 8'h40;
	localparam logic [7:0] OFS_CLR = 8'h50;
	localparam logic [7:0] OFS_NOT = 8'h60;
	localparam logic [7:0] OFS_PSEL0 = 8'h80;
	localparam logic [7:0] OFS_PSEL1 = 8'h84;
	localparam logic [7:0] OFS_ISEL = 8'h88;
	localparam logic [7:0] OFS_IENR = 8'h8C;
	localparam logic [7:0] OFS_IENF = 8'h90;
	localparam logic [7:0] OFS_IST = 8'h94;
	localparam logic [7:0] OFS_PMCTRL = 8'h98;
	localparam logic [7:0] OFS_PMSRC = 8'h9C;
	localparam logic [7:0] OFS_PMEND = 8'hA0;
	localparam logic [7:0] OFS_PMCOND = 8'hA4;
	localparam logic [7:0] OFS_GEN = 8'hB0;
	localparam logic [7:0] OFS_GPOL = 8'hB8;
	localparam logic [7:0] OFS_GCTRL = 8'hD0;
	localparam logic [7:0] OFS_GSTAT = 8'hD4;
	localparam logic [7:0] PORT_STEP = 8'h04;
	localparam logic [7:0] GRP_STEP = 8'h10;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int PMC_ENABLE = 0;
	localparam int PMC_EVENT = 1;
	localparam int PMC_EVPIN = 2;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [63:0] RST_OE_N = 64'hFFFF_FFFF_FFFF_FFFF;

	// ----------------------------------------
	// Slice conditions
	// ----------------------------------------
	localparam logic [2:0] CND_ALWAYS = 3'h0;
	localparam logic [2:0] CND_ST_RISE = 3'h1;
	localparam logic [2:0] CND_ST_FALL = 3'h2;
	localparam logic [2:0] CND_ST_EDGE = 3'h3;
	localparam logic [2:0] CND_HIGH = 3'h4;
	localparam logic [2:0] CND_LOW = 3'h5;
	localparam logic [2:0] CND_NEVER = 3'h6;
	localparam logic [2:0] CND_EVENT = 3'h7;

	typedef enum logic [1:0] {PWR_ACTIVE, PWR_SLEEP, PWR_DEEP, PWR_PDOWN} gpiopm_pwr_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic [3:0] be;
		logic wr;
		logic rd;
	} gpiopm_bus_t;

endpackage
`default_nettype wire

// File: sim/gpiopm_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module gpiopm_pin_model (
	input wire logic [63:0] pin_out,
	input wire logic [63:0] pin_oe_n,
	input wire logic [63:0] ext_level,
	output logic [63:0] pin_in
);
	// ----------------------------------------
	// Pin wire: the driven level wins, else the outside world
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < 64; i++) begin
			pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
		end
	end
endmodule
`default_nettype wire

// File: sim/gpiopm_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module gpiopm_top_test;
	import gpiopm_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	gpiopm_bus_t bus = '0;
	logic [31:0] rdata;
	logic [63:0] pin_in, pin_out, pin_oe_n;
	logic [63:0] periph_sel = '0;
	logic [63:0] periph_out = '0;
	logic [63:0] periph_oe_n = '1;
	logic [63:0] ext = '0;
	gpiopm_pwr_t power_mode = PWR_ACTIVE;
	logic [7:0] pint_irq, pm_irq;
	logic [1:0] gint_irq;
	logic cpu_receive_event, event_pin, wake_pint, wake_gint, wake_pm;
	int fails = 0;
	int comparisons = 0;
	int ev_cnt = 0;
	int evp_cnt = 0;
	logic [31:0] v;

	always #2 clock = ~clock;

	gpiopm_top dut (.clock(clock), .rst(rst), .bus(bus), .rdata(rdata), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .periph_sel(periph_sel),
		.periph_out(periph_out), .periph_oe_n(periph_oe_n), .power_mode(power_mode),
		.pint_irq(pint_irq), .gint_irq(gint_irq), .pm_irq(pm_irq),
		.cpu_receive_event(cpu_receive_event), .event_pin(event_pin),
		.wake_pint(wake_pint), .wake_gint(wake_gint), .wake_pm(wake_pm));

	gpiopm_pin_model pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext),
		.pin_in(pin_in));

	// Count event pulse cycles
	always @(posedge clock) begin
		if (cpu_receive_event === 1'b1) ev_cnt++;
		if (event_pin === 1'b1) evp_cnt++;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b = 4'hF);
		@(posedge clock);
		bus <= '{addr: a, wdata: d, be: b, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		bus <= '{addr: a, wdata: 32'h0000_0000, be: 4'hF, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic give_verdict;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		#1;
		chk(pin_oe_n, 64'hFFFF_FFFF_FFFF_FFFF, "oe after reset");
		rd(OFS_DIR, v);
		chk(v, 64'h0, "dir after reset");
		rd(8'hF0, v);
		chk(v, 64'h0, "unmapped read");
		$display("test reset done");
	endtask

	task automatic t_out;
		wr(OFS_DIR, 32'hFFFF_FFFF);
		wr(OFS_PIN, 32'h1234_5678);
		wr(OFS_SET, 32'h0000_0001);
		wr(OFS_CLR, 32'h0000_0010);
		wr(OFS_NOT, 32'h8000_0000);
		settle(2);
		chk(pin_out[31:0], 64'h9234_5669, "set clr toggle");
		chk(pin_oe_n[31:0], 64'h0, "all outputs");
		rd(OFS_PIN, v);
		chk(v, 64'h9234_5669, "pin level read");
		wr(OFS_DIR, 32'h0000_FFFF);
		settle(2);
		chk(pin_oe_n[31:0], 64'hFFFF_0000, "direction change");
		$display("test output done");
	endtask

	task automatic t_mask;
		wr(OFS_MASK, 32'h0000_00FF);
		wr(OFS_MPIN, 32'hFFFF_FFFF);
		wr(OFS_PIN, 32'h0000_AB00, 4'h2);
		wr(OFS_DIR + PORT_STEP, 32'h0000_0001);
		wr(OFS_SET + PORT_STEP, 32'h0000_0001);
		settle(2);
		chk(pin_out[31:0], 64'h9234_ABFF, "masked and byte writes");
		chk({pin_oe_n[32], pin_out[32]}, 64'h1, "port one bit zero");
		$display("test mask done");
	endtask

	task automatic t_periph;
		@(posedge clock);
		periph_sel[0] <= 1'b1;
		periph_oe_n[0] <= 1'b0;
		settle(4);
		chk(pin_out[0], 64'h0, "peripheral owns pin");
		rd(OFS_PIN, v);
		chk(v[0], 64'h0, "peripheral level read");
		@(posedge clock);
		periph_sel[0] <= 1'b0;
		$display("test periph done");
	endtask

	task automatic t_pint;
		wr(OFS_PSEL0, 32'h0000_0028);
		wr(OFS_IENR, 32'h0000_0001);
		power_mode <= PWR_SLEEP;
		ext[40] <= 1'b1;
		settle(8);
		chk({wake_pint, pint_irq}, 64'h101, "rising edge");
		@(posedge clock);
		ext[40] <= 1'b0;
		settle(8);
		chk(pint_irq, 64'h01, "edge held pending");
		wr(OFS_IST, 32'h0000_0001);
		settle(3);
		chk(pint_irq, 64'h00, "edge cleared");
		wr(OFS_IENR, 32'h0000_0000);
		wr(OFS_IENF, 32'h0000_0001);
		ext[40] <= 1'b1;
		settle(8);
		chk(pint_irq, 64'h00, "rising ignored");
		@(posedge clock);
		ext[40] <= 1'b0;
		power_mode <= PWR_PDOWN;
		settle(8);
		chk({wake_pint, pint_irq}, 64'h001, "falling edge");
		wr(OFS_IST, 32'h0000_0001);
		$display("test pin interrupt done");
	endtask

	task automatic t_level;
		wr(OFS_ISEL, 32'h0000_0001);
		wr(OFS_IENR, 32'h0000_0001);
		settle(8);
		chk(pint_irq, 64'h00, "high level absent");
		@(posedge clock);
		ext[40] <= 1'b1;
		settle(8);
		chk(pint_irq, 64'h01, "high level");
		wr(OFS_IENF, 32'h0000_0000);
		settle(4);
		chk(pint_irq, 64'h00, "low level absent");
		@(posedge clock);
		ext[40] <= 1'b0;
		settle(8);
		chk(pint_irq, 64'h01, "low level");
		wr(OFS_IENR, 32'h0000_0000);
		$display("test level done");
	endtask

	task automatic t_group;
		wr(OFS_GEN + PORT_STEP, 32'h0000_0100);
		wr(OFS_GPOL + PORT_STEP, 32'h0000_0100);
		power_mode <= PWR_PDOWN;
		settle(8);
		chk(gint_irq, 64'h0, "group idle");
		@(posedge clock);
		ext[40] <= 1'b1;
		settle(8);
		chk({wake_gint, gint_irq}, 64'h5, "group zero match");
		@(posedge clock);
		ext[40] <= 1'b0;
		settle(8);
		chk(gint_irq, 64'h0, "group released");
		wr(OFS_GEN + PORT_STEP, 32'h0000_0000);
		// Group one ANDs pins 32 and 40; port one drives pin 32 high
		wr(OFS_GCTRL, 32'h0000_0002);
		wr(OFS_GEN + GRP_STEP + PORT_STEP, 32'h0000_0101);
		wr(OFS_GPOL + GRP_STEP + PORT_STEP, 32'h0000_0101);
		settle(8);
		chk(gint_irq, 64'h0, "and needs every pin");
		@(posedge clock);
		ext[40] <= 1'b1;
		settle(8);
		chk(gint_irq, 64'h2, "group one and match");
		@(posedge clock);
		ext[40] <= 1'b0;
		wr(OFS_GEN + GRP_STEP + PORT_STEP, 32'h0000_0000);
		$display("test group done");
	endtask

	task automatic t_pattern;
		int ev0;
		int evp0;
		wr(OFS_ISEL, 32'h0000_0000);
		wr(OFS_PMCOND, 32'h00DB_6DB4);
		wr(OFS_PMEND, 32'h0000_0001);
		wr(OFS_PMCTRL, 32'h0000_0007);
		power_mode <= PWR_ACTIVE;
		settle(8);
		ev0 = ev_cnt;
		evp0 = evp_cnt;
		chk(pm_irq, 64'h00, "no term yet");
		@(posedge clock);
		ext[40] <= 1'b1;
		settle(8);
		chk({wake_pm, pm_irq}, 64'h101, "term zero match");
		chk(ev_cnt - ev0, 64'h1, "one event pulse");
		chk(evp_cnt - evp0, 64'h1, "event on pin");
		@(posedge clock);
		power_mode <= PWR_DEEP;
		settle(3);
		chk(wake_pm, 64'h0, "no pattern wake in deep");
		// Slice zero becomes sticky rise; the write re-arms it
		wr(OFS_PMCOND, 32'h00DB_6DB1);
		@(posedge clock);
		ext[40] <= 1'b0;
		settle(8);
		chk(pm_irq, 64'h00, "fall does not arm rise");
		@(posedge clock);
		ext[40] <= 1'b1;
		settle(8);
		@(posedge clock);
		ext[40] <= 1'b0;
		settle(8);
		chk(pm_irq, 64'h01, "sticky rise held");
		$display("test pattern done");
	endtask

	initial begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		t_reset();
		t_out();
		t_mask();
		t_periph();
		t_pint();
		t_level();
		t_group();
		t_pattern();
		give_verdict();
	end

	initial begin
		#40000;
		fails++;
		give_verdict();
	end
endmodule
`default_nettype wire
